// ---- core/smf_map.svh ----
// smf_map.svh: named offsets, widths and counts for the serial memory framing core
// assumes: included by bare name from core design files
`ifndef SMF_MAP_SVH
`define SMF_MAP_SVH

`define SMF_OPC_BITS   5'h08
`define SMF_ADDR_BITS  5'h18
`define SMF_MODE_BITS  5'h08
`define SMF_DATA_BITS  5'h08
`define SMF_ADDR_USED  19
`define SMF_KEEP_NIB   4'hA
`define SMF_KEEP_A5    8'hA5
`define SMF_LAT_W      4
`define SMF_LAT_ONE    4'h1
`define SMF_CNT_ZERO   5'h00
`define SMF_OPCNT_MAX  2'h3

`endif

// ---- core/smf_pkg.sv ----
// smf_pkg: types shared by the serial memory framing core
// assumes: compiled before any core module
package smf_pkg;

  typedef enum logic [1:0] {
    LANES_1 = 2'b00,
    LANES_2 = 2'b01,
    LANES_4 = 2'b10
  } lanes_t;

  // what the opcode decoder outside says about the received opcode
  typedef struct packed {
    logic   ddr;
    logic   has_addr;
    logic   has_mode;
    logic   keep_a5;
    logic   is_read;
    logic   reg_read;
    logic   wait_en;
    lanes_t addr_lanes;
    lanes_t data_lanes;
  } cmd_attr_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR   = 3'b011,
    ST_MODE   = 3'b010,
    ST_DUMMY  = 3'b110,
    ST_DOUT   = 3'b111,
    ST_DIN    = 3'b101
  } frame_state_t;

endpackage

// ---- core/smf_pin_sync.sv ----
// smf_pin_sync: two-flop synchroniser with edge detection for slow external pins
// assumes: pins change slower than a few reference clocks
`timescale 1ns/100ps
`default_nettype none

module smf_pin_sync #(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  // pins and their synchronised view
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~last_reg;
  assign fall_o  = ~sync_reg & last_reg;

endmodule // smf_pin_sync

`default_nettype wire

// ---- core/smf_frame.sv ----
// smf_frame: target-side command framing of a serial memory (opcode, address, mode, dummy, data)
// assumes: sck period of at least eight reference clocks; opcode decode supplied outside
`timescale 1ns/100ps
`default_nettype none

`include "smf_map.svh"

// Behaviour
// - while deselected ignore inputs and keep all data pins undriven
// - each selection starts at chip-select fall and carries one opcode only
// - sdr: sample on rising sck, change outputs on falling sck
// - opcode, address and data travel most significant bit first
// - take a three-byte address, keep only the low 19 bits
// - first byte after selection is the opcode; address, mode, data follow
// - keep-pattern mode byte holds execute-in-place; next selection starts at address
// - any other mode byte ends execute-in-place; next selection needs opcode
// - only opcodes with a mode phase may enter execute-in-place
// - mode byte spans one clock in quad ddr up to eight in sdr
// - reads with wait states insert configured dummy cycles; memory and register counts differ
// - each dummy cycle is one full sck period; data pins ignored
// - sck level at chip-select fall picks clock mode 0 or 3
// - with sck idling high, ignore the first edge; sample from first rise
// - ddr: opcode on rises, address and data on both edges after opcode
// - ddr reads drive first bit on falling edge closing the last dummy cycle
// - each selection outside execute-in-place starts single line; lane width follows opcode only
module smf_frame
  import smf_pkg::*;
#(
  parameter int LAT_W = `SMF_LAT_W
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  // serial memory pins
  input  wire logic             sck_i,
  input  wire logic             cs_n_i,
  input  wire logic [3:0]       io_i,
  output logic      [3:0]       io_o,
  output logic      [3:0]       io_oe_o,
  // opcode decoder and latency configuration
  input  wire cmd_attr_t        cmd_attr_i,
  input  wire logic [LAT_W-1:0] memory_latency_config_i,
  input  wire logic [LAT_W-1:0] register_latency_config_i,
  // memory side
  output logic      [7:0]       opcode_o,
  output logic                  opcode_valid_o,
  output logic      [18:0]      addr_o,
  output logic                  addr_valid_o,
  output logic      [7:0]       wr_data_o,
  output logic                  wr_valid_o,
  input  wire logic [7:0]       rd_data_i,
  output logic                  rd_take_o,
  // status
  output logic                  execute_in_place_state_o,
  output logic                  clock_mode3_o,
  output logic                  selected_o
);

  function automatic logic [4:0] lane_n(input lanes_t l);
    unique case (l)
      LANES_2: lane_n = 5'h02;
      LANES_4: lane_n = 5'h04;
      default: lane_n = 5'h01;
    endcase
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] cur, input logic [3:0] d, input lanes_t l);
    unique case (l)
      LANES_2: shift_in = {cur[21:0], d[1:0]};
      LANES_4: shift_in = {cur[19:0], d[3:0]};
      default: shift_in = {cur[22:0], d[0]};
    endcase
  endfunction

  // single line answers on io[1], wider ones on io[1:0] or io[3:0]
  function automatic logic [3:0] lane_out(input logic [7:0] b, input lanes_t l);
    unique case (l)
      LANES_2: lane_out = {2'b00, b[7:6]};
      LANES_4: lane_out = b[7:4];
      default: lane_out = {2'b00, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] lane_oe(input lanes_t l);
    unique case (l)
      LANES_2: lane_oe = 4'h3;
      LANES_4: lane_oe = 4'hF;
      default: lane_oe = 4'h2;
    endcase
  endfunction

  function automatic logic [7:0] byte_shift(input logic [7:0] b, input lanes_t l);
    unique case (l)
      LANES_2: byte_shift = {b[5:0], 2'b00};
      LANES_4: byte_shift = {b[3:0], 4'h0};
      default: byte_shift = {b[6:0], 1'b0};
    endcase
  endfunction

  function automatic logic [LAT_W-1:0] pick_lat(input logic rr, input logic [LAT_W-1:0] mem_lat,
                                                input logic [LAT_W-1:0] reg_lat);
    pick_lat = rr ? reg_lat : mem_lat;
  endfunction

  function automatic frame_state_t after_mode(input cmd_attr_t a, input logic lat_zero);
    if (!a.is_read)
      after_mode = ST_DIN;
    else if (a.wait_en && !lat_zero)
      after_mode = ST_DUMMY;
    else
      after_mode = ST_DOUT;
  endfunction

  // only opcodes with a mode phase reach the keep-pattern test
  function automatic frame_state_t after_addr(input cmd_attr_t a, input logic lat_zero);
    after_addr = a.has_mode ? ST_MODE : after_mode(a, lat_zero);
  endfunction

  // pin synchroniser: bit 0 sck, bit 1 select (inverted so reset reads deselected), bits 5:2 data
  logic [5:0] pin_lvl;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;

  smf_pin_sync #(
    .W (6)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .pin_i     ({io_i, ~cs_n_i, sck_i}),
    .level_o   (pin_lvl),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  frame_state_t     state_reg;
  cmd_attr_t        attr_reg;
  logic [4:0]       cnt_reg;
  logic [23:0]      sh_reg;
  logic [LAT_W-1:0] lat_reg;
  logic [7:0]       out_reg;
  logic [3:0]       out_left_reg;
  logic             armed_reg;
  logic             dec_pend_reg;
  logic             xip_reg;
  logic [1:0]       op_cnt_reg;

  wire logic       sck_lvl  = pin_lvl[0];
  wire logic       sck_rise = pin_rise[0];
  wire logic       sck_fall = pin_fall[0];
  wire logic       cs_fall  = pin_rise[1];
  wire logic       selected = pin_lvl[1];
  wire logic [3:0] io_lvl   = pin_lvl[5:2];
  wire logic       live     = selected & ~cs_fall;

  wire lanes_t     cur_lanes = (state_reg == ST_OPCODE) ? LANES_1 :
                               (state_reg == ST_DIN)    ? attr_reg.data_lanes : attr_reg.addr_lanes;
  wire logic       in_phase  = (state_reg == ST_ADDR) | (state_reg == ST_MODE) | (state_reg == ST_DIN);
  // opcode bits start on rises only, so a mode-3 first fall is ignored
  // ddr falls count only after the first rise past the opcode
  wire logic       samp      = live & ((sck_rise & (in_phase | (state_reg == ST_OPCODE))) |
                                       (sck_fall & attr_reg.ddr & armed_reg & in_phase));
  // mode byte rides the address lanes and edges, one clock in quad ddr
  wire logic [4:0] cnt_next  = cnt_reg + lane_n(cur_lanes);
  wire logic [23:0] sh_next  = shift_in(sh_reg, io_lvl, cur_lanes);
  wire logic [4:0] target    = (state_reg == ST_ADDR) ? `SMF_ADDR_BITS :
                               (state_reg == ST_MODE) ? `SMF_MODE_BITS :
                               (state_reg == ST_DIN)  ? `SMF_DATA_BITS : `SMF_OPC_BITS;
  wire logic       phase_done = samp & (cnt_next == target);

  // keep pattern is a full byte or the upper nibble, per opcode
  wire logic       keep_now  = attr_reg.keep_a5 ? (sh_next[7:0] == `SMF_KEEP_A5) :
                                                  (sh_next[7:4] == `SMF_KEEP_NIB);
  wire logic [LAT_W-1:0] lat_dec = pick_lat(cmd_attr_i.reg_read, memory_latency_config_i,
                                            register_latency_config_i);
  wire logic [LAT_W-1:0] lat_xip = pick_lat(attr_reg.reg_read, memory_latency_config_i,
                                            register_latency_config_i);
  wire frame_state_t first_ph = cmd_attr_i.has_addr ? ST_ADDR : after_addr(cmd_attr_i, lat_dec == '0);
  wire frame_state_t addr_nxt = after_addr(attr_reg, lat_reg == '0);
  wire frame_state_t mode_nxt = after_mode(attr_reg, lat_reg == '0);

  // one dummy cycle per full sck period
  wire logic       dum_edge  = live & (state_reg == ST_DUMMY) & (attr_reg.ddr ? sck_fall : sck_rise);
  wire logic       dum_last  = dum_edge & (lat_reg == `SMF_LAT_ONE);
  // ddr first bit on the fall closing the last dummy cycle
  wire logic       drive_now = live & (((state_reg == ST_DOUT) &
                                        (sck_fall | (attr_reg.ddr & sck_rise & (|io_oe_o)))) |
                                       (dum_last & attr_reg.ddr));
  wire logic       load_now  = drive_now & (out_left_reg == 4'h0);
  wire logic [7:0] out_byte  = load_now ? rd_data_i : out_reg;
  wire logic [4:0] out_lanes = lane_n(attr_reg.data_lanes);
  wire logic [3:0] out_step  = out_lanes[3:0];

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg    <= ST_IDLE;
      attr_reg     <= '0;
      cnt_reg      <= `SMF_CNT_ZERO;
      sh_reg       <= '0;
      lat_reg      <= '0;
      armed_reg    <= 1'b0;
      dec_pend_reg <= 1'b0;
      xip_reg      <= 1'b0;
    end else if (!selected) begin
      // deselected: drop the frame, keep only the resume state
      state_reg    <= ST_IDLE;
      dec_pend_reg <= 1'b0;
    end else if (cs_fall) begin
      cnt_reg      <= `SMF_CNT_ZERO;
      armed_reg    <= 1'b0;
      lat_reg      <= lat_xip;
      state_reg    <= xip_reg ? ST_ADDR : ST_OPCODE;
    end else if (dec_pend_reg) begin
      dec_pend_reg <= 1'b0;
      attr_reg     <= cmd_attr_i;
      lat_reg      <= lat_dec;
      state_reg    <= first_ph;
    end else begin
      if (samp) begin
        sh_reg    <= sh_next;
        cnt_reg   <= phase_done ? `SMF_CNT_ZERO : cnt_next;
        armed_reg <= (state_reg != ST_OPCODE);
      end
      if (phase_done) begin
        unique case (state_reg)
          // first byte is the opcode; decode follows one cycle later
          ST_OPCODE: begin
            state_reg    <= ST_ADDR;
            dec_pend_reg <= 1'b1;
          end
          ST_ADDR: state_reg <= addr_nxt;
          ST_MODE: begin
            // anything but the keep pattern leaves execute-in-place
            xip_reg      <= keep_now;
            state_reg    <= mode_nxt;
          end
          default: state_reg <= state_reg;
        endcase
      end
      if (dum_edge) begin
        // count down the configured wait cycles
        lat_reg <= lat_reg - `SMF_LAT_ONE;
        if (dum_last)
          state_reg <= ST_DOUT;
      end
    end
  end

  // data path and outputs
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_o           <= 4'h0;
      io_oe_o        <= 4'h0;
      out_reg        <= 8'h00;
      out_left_reg   <= 4'h0;
      opcode_o       <= 8'h00;
      opcode_valid_o <= 1'b0;
      addr_o         <= '0;
      addr_valid_o   <= 1'b0;
      wr_data_o      <= 8'h00;
      wr_valid_o     <= 1'b0;
      rd_take_o      <= 1'b0;
      selected_o     <= 1'b0;
      clock_mode3_o  <= 1'b0;
      execute_in_place_state_o <= 1'b0;
    end else begin
      selected_o     <= selected;
      execute_in_place_state_o <= xip_reg;
      opcode_valid_o <= phase_done & (state_reg == ST_OPCODE);
      addr_valid_o   <= phase_done & (state_reg == ST_ADDR);
      wr_valid_o     <= phase_done & (state_reg == ST_DIN);
      rd_take_o      <= load_now;
      // sck level at selection picks clock mode 3
      if (cs_fall)
        clock_mode3_o <= sck_lvl;
      if (phase_done & (state_reg == ST_OPCODE))
        opcode_o <= sh_next[7:0];
      // only the low address bits reach the array
      if (phase_done & (state_reg == ST_ADDR))
        addr_o <= sh_next[`SMF_ADDR_USED-1:0];
      if (phase_done & (state_reg == ST_DIN))
        wr_data_o <= sh_next[7:0];
      if (!selected | cs_fall) begin
        io_oe_o      <= 4'h0;
        out_left_reg <= 4'h0;
      end else if (drive_now) begin
        // output bits change on the drive edge only
        io_o         <= lane_out(out_byte, attr_reg.data_lanes);
        io_oe_o      <= lane_oe(attr_reg.data_lanes);
        out_reg      <= byte_shift(out_byte, attr_reg.data_lanes);
        out_left_reg <= (load_now ? 4'h8 : out_left_reg) - out_step;
      end
    end
  end

  // one opcode per selection, counted for checking
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      op_cnt_reg <= 2'h0;
    else if (cs_fall)
      op_cnt_reg <= 2'h0;
    else if (opcode_valid_o && op_cnt_reg != `SMF_OPCNT_MAX)
      op_cnt_reg <= op_cnt_reg + 2'h1;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_idle_pins_off: assert property (!selected |=> io_oe_o == 4'h0)
    else $error("data pins driven while deselected");
  a_one_opcode: assert property (op_cnt_reg <= 2'h1)
    else $error("more than one opcode in a selection");
  a_opcode_rise: assert property (opcode_valid_o |-> $past(sck_rise))
    else $error("opcode completed off a rising edge");
  a_sdr_drive_fall: assert property (io_oe_o != 4'h0 && !attr_reg.ddr && $changed(io_o) |-> $past(sck_fall))
    else $error("sdr output changed off a falling edge");
  a_xip_resume: assert property (cs_fall && xip_reg |=> state_reg == ST_ADDR ##1 !opcode_valid_o)
    else $error("execute-in-place selection did not start at address");
  a_new_opcode: assert property (cs_fall && !xip_reg |=> state_reg == ST_OPCODE)
    else $error("selection outside execute-in-place skipped the opcode");
  a_xip_mode_only: assert property ($rose(xip_reg) |-> attr_reg.has_mode && $past(state_reg) == ST_MODE)
    else $error("execute-in-place without a mode phase");
  a_mode3_pick: assert property (cs_fall |=> clock_mode3_o == $past(sck_lvl))
    else $error("clock mode not taken from sck at selection");
  a_ddr_skip_fall: assert property (selected && !cs_fall && state_reg == ST_ADDR && attr_reg.ddr && !armed_reg
                                    && sck_fall && !dec_pend_reg |=> $stable(cnt_reg))
    else $error("ddr address sampled on the fall ending the opcode");
  a_dummy_quiet: assert property (state_reg == ST_DUMMY |-> io_oe_o == 4'h0)
    else $error("output driven during dummy cycles");
  a_addr_strobe: assert property (addr_valid_o |-> $past(state_reg == ST_ADDR && samp))
    else $error("address strobe without a completed address");

endmodule // smf_frame

`default_nettype wire

// ---- tb/smf_host_model.sv ----
// smf_host_model: behavioural serial host, single lane plus quad ddr writes, framing commands for one target
// assumes: sck half period of 400 ns; the bench resolves the data wires and their pull-ups
`timescale 1ns/100ps
`default_nettype none

module smf_host_model (
  // link pins driven by the host
  output logic       sck_o,
  output logic       cs_n_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // resolved data wires
  input  wire logic [3:0] io_i
);
  logic idle_lvl;

  initial begin
    sck_o    = 1'b0;
    cs_n_o   = 1'b1;
    io_o     = 4'h0;
    io_oe_o  = 4'h0;
    idle_lvl = 1'b0;
  end

  // chip-select fall with sck idling at the clock-mode level, io[0] driven
  task automatic select(input logic m3);
    idle_lvl = m3;
    sck_o    = m3;
    #400;
    cs_n_o   = 1'b0;
    io_oe_o  = 4'b0001;
    #400;
  endtask

  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sck_o    = 1'b0;
      io_o[0]  = v[i];
      #400;
      sck_o    = 1'b1;
      #400;
    end
  endtask

  // quad ddr: a nibble per edge, first on the rise after the idle-low fall
  task automatic send_ddr(input logic [31:0] v, input int n);
    io_oe_o = 4'hF;
    if (sck_o)
      sck_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #200;
      io_o  = v[4*i +: 4];
      #200;
      sck_o = ~sck_o;
    end
  endtask

  // released wires float to the pull-up; data is taken halfway through the high phase
  task automatic recv(output logic [7:0] b);
    io_oe_o = 4'h0;
    b       = 8'h00;
    for (int i = 0; i < 8; i++) begin
      sck_o = 1'b0;
      #400;
      sck_o = 1'b1;
      #200;
      b     = {b[6:0], io_i[1]};
      #200;
    end
  endtask

  task automatic deselect();
    sck_o   = idle_lvl;
    #400;
    cs_n_o  = 1'b1;
    io_oe_o = 4'h0;
    #400;
  endtask
endmodule // smf_host_model

`default_nettype wire

// ---- tb/serial_memory_spi_slave_framing_bench.sv ----
// serial_memory_spi_slave_framing_bench: self-checking bench of the framing core
// assumes: the host model stands on the link; every data wire has a pull-up
`timescale 1ns/100ps
`default_nettype none

module serial_memory_spi_slave_framing_bench;
  import smf_pkg::*;

  typedef struct packed {
    logic [7:0]  opc;
    logic [23:0] adr;
    logic        m3;
    logic [18:0] exp_adr;
  } row_t;

  localparam row_t ROWS [3] = '{
    '{8'h03, 24'h07_ABCD, 1'b0, 19'h7_ABCD},
    '{8'h02, 24'hF8_0001, 1'b0, 19'h0_0001},
    '{8'h0B, 24'h05_5AA5, 1'b1, 19'h5_5AA5}
  };

  logic        ref_clk_i;
  logic        resetn_i;
  logic        sck, cs_n;
  logic [3:0]  h_io, h_oe, d_io, d_oe, io_w;
  cmd_attr_t   attr;
  logic [3:0]  mem_lat, reg_lat;
  logic [7:0]  rd_data, opc, wr_data, b;
  logic [18:0] adr;
  logic        opc_v, adr_v, wr_v, take, execute_in_place_state, m3, sel;
  int          failures, cmp_count, n_opc, n_wr, n_adr, n_take;

  // pull-up on every data wire when nobody drives it
  assign io_w = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe);

  smf_frame u_smf_frame (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n),
    .io_i(io_w), .io_o(d_io), .io_oe_o(d_oe), .cmd_attr_i(attr),
    .memory_latency_config_i(mem_lat), .register_latency_config_i(reg_lat),
    .opcode_o(opc), .opcode_valid_o(opc_v), .addr_o(adr), .addr_valid_o(adr_v),
    .wr_data_o(wr_data), .wr_valid_o(wr_v), .rd_data_i(rd_data), .rd_take_o(take),
    .execute_in_place_state_o(execute_in_place_state), .clock_mode3_o(m3), .selected_o(sel)
  );

  smf_host_model u_smf_host_model (
    .sck_o(sck), .cs_n_o(cs_n), .io_o(h_io), .io_oe_o(h_oe), .io_i(io_w)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (opc_v === 1'b1) n_opc++;
    if (wr_v === 1'b1) n_wr++;
    if (adr_v === 1'b1) n_adr++;
    if (take === 1'b1) n_take++;
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic set_attr(input logic hm, input logic rd, input logic rg, input logic we);
    settle(1);
    attr = '{1'b0, 1'b1, hm, 1'b0, rd, rg, we, LANES_1, LANES_1};
  endtask

  // one frame after an optional opcode: address, then an optional mode byte
  task automatic frame(input logic op_on, input logic [7:0] op, input logic [23:0] a,
                       input logic md_on, input logic [7:0] md);
    u_smf_host_model.select(1'b0);
    if (op_on) u_smf_host_model.send(op, 8);
    u_smf_host_model.send(a, 24);
    if (md_on) u_smf_host_model.send(md, 8);
    settle(8);
    u_smf_host_model.deselect();
    settle(4);
  endtask

  // quad ddr write frame: optional sdr opcode, address, mode byte and one data byte
  task automatic ddr_frame(input logic op_on, input logic [23:0] a, input logic [7:0] md,
                           input logic [7:0] d);
    u_smf_host_model.select(1'b0);
    if (op_on) u_smf_host_model.send(8'hED, 8);
    u_smf_host_model.send_ddr(a, 6);
    u_smf_host_model.send_ddr(md, 2);
    u_smf_host_model.send_ddr(d, 2);
    settle(8);
    u_smf_host_model.deselect();
    settle(4);
  endtask

  initial begin
    #5_000_000;
    failures++;
    test_done();
  end

  initial begin
    failures  = 0;
    cmp_count = 0;
    n_opc     = 0;
    n_wr      = 0;
    n_adr     = 0;
    n_take    = 0;
    resetn_i  = 1'b0;
    attr      = '0;
    mem_lat   = 4'h2;
    reg_lat   = 4'h3;
    rd_data   = 8'hC6;
    settle(6);
    resetn_i  = 1'b1;
    settle(4);
    check("selected", sel, 0);
    check("oe idle", d_oe, 0);
    check("xip reset", execute_in_place_state, 0);
    $display("test reset done");
    set_attr(1'b0, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      u_smf_host_model.select(ROWS[i].m3);
      u_smf_host_model.send(ROWS[i].opc, 8);
      u_smf_host_model.send(ROWS[i].adr, 24);
      settle(8);
      check("opcode", opc, ROWS[i].opc);
      check("address", adr, ROWS[i].exp_adr);
      check("clock mode", m3, ROWS[i].m3);
      check("opcode count", n_opc, i + 1);
      check("address strobe", n_adr, i + 1);
      check("selected", sel, 1);
      u_smf_host_model.deselect();
      settle(4);
    end
    $display("test rows done");
    u_smf_host_model.select(1'b0);
    u_smf_host_model.send(8'h02, 8);
    u_smf_host_model.send(24'h00_0010, 24);
    u_smf_host_model.send(8'h5A, 8);
    u_smf_host_model.send(3'b101, 3);
    settle(8);
    u_smf_host_model.deselect();
    settle(4);
    check("write byte", wr_data, 8'h5A);
    check("write count", n_wr, 1);
    u_smf_host_model.send(8'h03, 8);
    settle(8);
    check("deselected opcode", n_opc, 4);
    check("deselected oe", d_oe, 0);
    $display("test write and deselect done");
    for (int rs = 0; rs < 2; rs++) begin
      set_attr(1'b0, 1'b1, rs[0], 1'b1);
      u_smf_host_model.select(1'b0);
      u_smf_host_model.send(8'h03, 8);
      u_smf_host_model.send(24'h00_0100, 24);
      u_smf_host_model.send(0, rs ? int'(reg_lat) : int'(mem_lat));
      u_smf_host_model.recv(b);
      check("read oe", d_oe, 4'b0010);
      check("read take", n_take, 2 * rs + 1);
      u_smf_host_model.deselect();
      settle(4);
      check("read byte", b, 8'hC6);
    end
    $display("test reads done");
    set_attr(1'b1, 1'b0, 1'b0, 1'b0);
    frame(1'b1, 8'hEB, 24'h00_0020, 1'b1, 8'hA3);
    check("xip set", execute_in_place_state, 1);
    frame(1'b0, 8'h00, 24'h01_2345, 1'b1, 8'hA0);
    check("xip address", adr, 19'h1_2345);
    check("xip no opcode", n_opc, 7);
    check("xip kept", execute_in_place_state, 1);
    frame(1'b0, 8'h00, 24'h00_0030, 1'b1, 8'h5F);
    check("xip left", execute_in_place_state, 0);
    set_attr(1'b0, 1'b0, 1'b0, 1'b0);
    frame(1'b1, 8'h02, 24'h00_0040, 1'b1, 8'hA0);
    check("fresh opcode", n_opc, 8);
    check("no mode phase", execute_in_place_state, 0);
    $display("test execute in place done");
    settle(1);
    attr = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, LANES_4, LANES_4};
    ddr_frame(1'b1, 24'h00_3456, 8'hA5, 8'h9C);
    check("ddr opcode", opc, 8'hED);
    check("ddr address", adr, 19'h0_3456);
    check("ddr write", wr_data, 8'h9C);
    check("ddr keep byte", execute_in_place_state, 1);
    ddr_frame(1'b0, 24'h04_0077, 8'hA0, 8'h3B);
    check("ddr xip address", adr, 19'h4_0077);
    check("ddr xip write", wr_data, 8'h3B);
    check("ddr keep miss", execute_in_place_state, 0);
    check("ddr opcode count", n_opc, 9);
    $display("test ddr done");
    test_done();
  end
endmodule // serial_memory_spi_slave_framing_bench

`default_nettype wire
